// >>> ddr3_link_pkg.sv
// Shared constants and types for the DDR3 command/address link model.
// Assumes both ends run from one 25 MHz core clock; the link clock is a pin.
package ddr3_link_pkg;
    localparam int BANK_COUNT = 8;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 16;
    localparam int COL_W = 10;
    localparam int DATA_W = 8;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    // Mode register 0 and 1 fields
    localparam int MR_BL_POS = 0;
    localparam int MR_BT_POS = 3;
    localparam int MR_AL_POS = 3;
    localparam logic [1:0] MR0_RESET = 2'h0;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [1:0] AL_ZERO = 2'h0;
    localparam logic [1:0] AL_CL1 = 2'h1;
    localparam logic [1:0] AL_CL2 = 2'h2;
    localparam int CAS_LATENCY = 5;
    // Refresh spacing (ns) and derived core cycles
    localparam int CORE_PERIOD_NS = 40;
    localparam int REFI_NORMAL_NS = 7800;
    localparam int REFI_HOT_NS = 3900;
    localparam int REFI_NORMAL_CYC = REFI_NORMAL_NS / CORE_PERIOD_NS;
    localparam int REFI_HOT_CYC = REFI_HOT_NS / CORE_PERIOD_NS;
    localparam int LINK_DIV = 4;
    // Command code {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_NOP = 4'h7,
        CMD_DES = 4'h8
    } cmd_type;
endpackage : ddr3_link_pkg

// >>> ddr3_link_if.sv
// Pins between controller and memory device.
// Strobe and data are two-way: each end gives output and enable, wire resolved here.
`timescale 1ns/1ns
interface ddr3_link_if;
    logic ck;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [15:0] addr;
    logic [7:0] ctl_dq;
    logic ctl_dq_oe;
    logic ctl_dqs;
    logic ctl_dqs_oe;
    logic [7:0] mem_dq;
    logic mem_dq_oe;
    logic mem_dqs;
    logic mem_dqs_oe;
    logic [7:0] dq;
    logic dqs;
    assign dq = ctl_dq_oe ? ctl_dq : (mem_dq_oe ? mem_dq : 8'h00);
    assign dqs = ctl_dqs_oe ? ctl_dqs : (mem_dqs_oe ? mem_dqs : 1'b0);
    modport controller (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
        ctl_dq, ctl_dq_oe, ctl_dqs, ctl_dqs_oe, input dq, dqs);
    modport memory (input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dqs,
        output mem_dq, mem_dq_oe, mem_dqs, mem_dqs_oe);
endinterface : ddr3_link_if

// >>> ddr3_memory_end.sv
// Memory device end: samples command/address on rising link clock, 8 banks.
// Assumes link clock and pins are asynchronous; all pass two flip-flops.
// Behaviour
// - Sample inputs only on rising link clock (write data is taken on strobe edges)
// - Read data on both clock edges
// - CKE low freezes internal clock, state
// - CKE low while idle: power-down/self-refresh
// - Eight banks each with open row
// - Bank address selects command target bank
// - Row from A0-A15, column A0-A9 (code takes column from A0-A2 only)
// - Mode register set loads address op-code
// - Burst length four or eight
// - Sequential or interleaved burst order
// - Additive latency 0, CL-1, CL-2
// - Controller refreshes every 7.8us normally
// - Controller refreshes every 3.9us when hot
// - Auto refresh and self refresh supported
// - Data travels with sender's strobe
// - A10 auto-precharge or all-bank precharge
// - A12 low chops burst on fly
// - Chip select high masks command
// - Decode activate/precharge/read/write from strobes
`timescale 1ns/1ns
module ddr3_memory_end
    import ddr3_link_pkg::*;
#(
    parameter int DEPTH_W = 4
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // Link
    ddr3_link_if.memory link,
    // Status
    output logic powerdown_out,
    output logic self_refresh_out,
    output logic [7:0] open_banks_out,
    output logic [1:0] mode_bl_out,
    output logic [15:0] refresh_count_out
);
    initial begin
        if (DEPTH_W < 1 || DEPTH_W > 12) $error("DEPTH_W out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } burst_state_type;

    // Two-flop synchronisers for all pins
    localparam int PIN_W = 1 + 1 + 4 + BANK_W + ADDR_W + DATA_W + 1;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                link.ba, link.addr, link.dq, link.dqs};
            pin_sync <= pin_meta;
        end
    end
    wire logic s_ck = pin_sync[PIN_W-1];
    wire logic s_cke = pin_sync[PIN_W-2];
    wire logic [3:0] s_cmd = pin_sync[PIN_W-3 -: 4];
    wire logic [2:0] s_ba = pin_sync[PIN_W-7 -: 3];
    wire logic [15:0] s_addr = pin_sync[PIN_W-10 -: 16];
    wire logic [7:0] s_dq = pin_sync[8:1];
    wire logic s_dqs = pin_sync[0];

    logic ck_d;
    logic dqs_d;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ck_d <= 1'b0;
            dqs_d <= 1'b0;
        end else begin
            ck_d <= s_ck;
            dqs_d <= s_dqs;
        end
    end
    wire logic ck_rise = s_ck && !ck_d;
    wire logic ck_fall = !s_ck && ck_d;
    wire logic dqs_edge = s_dqs != dqs_d;

    // Internal clock runs only while CKE was high on the previous rise
    logic cke_prev;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) cke_prev <= 1'b0;
        else if (ck_rise) cke_prev <= s_cke;
    end
    wire logic tick = ck_rise && cke_prev && s_cke;

    // Command decode; CS high masks everything
    cmd_type cmd;
    always_comb begin
        if (s_cmd[3]) cmd = CMD_DES;
        else cmd = cmd_type'(s_cmd);
    end

    logic [7:0] bank_open;
    logic [15:0] bank_row [BANK_COUNT];
    logic [1:0] mr_bl;
    logic mr_bt;
    logic [1:0] mr_al;
    logic [7:0] mem [2**DEPTH_W];
    burst_state_type state;
    logic [2:0] beat;
    logic [2:0] beats_last;
    logic [2:0] col_base;
    logic [2:0] burst_bank;
    logic burst_ap;
    logic [3:0] wait_cnt;
    wire logic all_idle = bank_open == 8'h00;
    wire logic [2:0] col_index = mr_bt ? (col_base ^ beat) : (col_base + beat);

    // Power-down and self-refresh entry on a falling CKE with all banks idle
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            powerdown_out <= 1'b0;
            self_refresh_out <= 1'b0;
        end else if (ck_rise) begin
            if (cke_prev && !s_cke && all_idle && state == ST_IDLE) begin
                self_refresh_out <= cmd == CMD_REF;
                powerdown_out <= cmd != CMD_REF;
            end else if (s_cke) begin
                powerdown_out <= 1'b0;
                self_refresh_out <= 1'b0;
            end
        end
    end

    // Refresh counter counts auto refreshes and self-refresh periods
    logic [11:0] sr_timer;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            refresh_count_out <= 16'h0000;
            sr_timer <= 12'h000;
        end else if (self_refresh_out) begin
            sr_timer <= sr_timer + 12'h001;
            if (sr_timer == 12'(REFI_HOT_CYC)) begin
                sr_timer <= 12'h000;
                refresh_count_out <= refresh_count_out + 16'h0001;
            end
        end else if (tick && cmd == CMD_REF && all_idle) begin
            refresh_count_out <= refresh_count_out + 16'h0001;
        end
    end

    // Mode register: A[1:0] burst length, A3 order, MR1 A[4:3] additive latency
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mr_bl <= BL_FIXED8;
            mr_bt <= 1'b0;
            mr_al <= AL_ZERO;
        end else if (tick && cmd == CMD_MRS) begin
            if (s_ba == 3'h0) begin
                mr_bl <= s_addr[MR_BL_POS +: 2];
                mr_bt <= s_addr[MR_BT_POS];
            end else if (s_ba == 3'h1) begin
                mr_al <= s_addr[MR_AL_POS +: 2];
            end
        end
    end
    assign mode_bl_out = mr_bl;

    // Bank open state
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bank_open <= 8'h00;
            for (int i = 0; i < BANK_COUNT; i++) bank_row[i] <= 16'h0000;
        end else begin
            if (tick && cmd == CMD_ACT) begin
                bank_open[s_ba] <= 1'b1;
                bank_row[s_ba] <= s_addr;
            end else if (tick && cmd == CMD_PRE) begin
                if (s_addr[AP_BIT]) bank_open <= 8'h00;
                else bank_open[s_ba] <= 1'b0;
            end
            if (state != ST_IDLE && beat == beats_last && burst_ap && wait_cnt == 4'h0 &&
                    (state == ST_WRITE ? dqs_edge : (ck_rise || ck_fall)))
                bank_open[burst_bank] <= 1'b0;
        end
    end
    assign open_banks_out = bank_open;

    // Burst engine: posted commands wait AL, then data starts with no CL wait; frozen while CKE low
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_IDLE;
            beat <= 3'h0;
            beats_last <= 3'h7;
            col_base <= 3'h0;
            burst_bank <= 3'h0;
            burst_ap <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (tick && (cmd == CMD_RD || cmd == CMD_WR) && bank_open[s_ba]) begin
                        state <= cmd == CMD_RD ? ST_READ : ST_WRITE;
                        burst_bank <= s_ba;
                        col_base <= s_addr[2:0];
                        burst_ap <= s_addr[AP_BIT];
                        beat <= 3'h0;
                        if (mr_bl == BL_FIXED4 || (mr_bl == BL_OTF && !s_addr[BC_BIT]))
                            beats_last <= 3'h3;
                        else beats_last <= 3'h7;
                        case (mr_al)
                            AL_CL1: wait_cnt <= 4'(CAS_LATENCY - 1);
                            AL_CL2: wait_cnt <= 4'(CAS_LATENCY - 2);
                            default: wait_cnt <= 4'h0;
                        endcase
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (wait_cnt != 4'h0) begin
                        if (tick) wait_cnt <= wait_cnt - 4'h1;
                    end else if (cke_prev && (state == ST_WRITE ? dqs_edge
                            : (ck_rise || ck_fall))) begin
                        beat <= beat + 3'h1;
                        if (beat == beats_last) state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Small array stands in for the open row; indexed by bank and column
    wire logic [DEPTH_W-1:0] mem_index = DEPTH_W'({burst_bank, col_index});
    always_ff @(posedge core_clk_in) begin
        if (state == ST_WRITE && wait_cnt == 4'h0 && dqs_edge && cke_prev)
            mem[mem_index] <= s_dq;
    end

    // Read data and strobe change on both link clock edges
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link.mem_dq <= 8'h00;
            link.mem_dq_oe <= 1'b0;
            link.mem_dqs <= 1'b0;
            link.mem_dqs_oe <= 1'b0;
        end else if (state == ST_READ && wait_cnt == 4'h0) begin
            if (cke_prev && (ck_rise || ck_fall)) begin
                link.mem_dq <= mem[mem_index];
                link.mem_dqs <= ck_rise;
                link.mem_dq_oe <= 1'b1;
                link.mem_dqs_oe <= 1'b1;
            end
        end else if (ck_rise || ck_fall) begin
            // Last beat stands until the next crossing, like every other beat
            link.mem_dq_oe <= 1'b0;
            link.mem_dqs_oe <= 1'b0;
        end
    end
endmodule : ddr3_memory_end

// >>> ddr3_ctrl_end.sv
// Controller end: makes link clock by divider, sends commands, paces refresh.
// Assumes one user request at a time through a two-entry buffer.
`timescale 1ns/1ns
module ddr3_ctrl_end
    import ddr3_link_pkg::*;
#(
    parameter int REFI_CYC = REFI_NORMAL_CYC
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // User request
    input wire logic req_valid_in,
    input wire logic [3:0] req_cmd_in,
    input wire logic [2:0] req_ba_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [7:0] req_data_in,
    input wire logic req_cke_in,
    input wire logic hot_in,
    output logic req_ready_out,
    output logic refresh_due_out,
    // Link
    ddr3_link_if.controller link
);
    initial begin
        if (REFI_CYC < 2) $error("REFI_CYC too small");
    end

    // Two-entry buffer holds requests so a stalled link loses none
    logic [31:0] buf_q [2];
    logic [1:0] buf_cnt;
    logic buf_wp;
    logic buf_rp;
    logic link_ready;
    // Taken only while ready is shown, so a request held until ready is not pushed twice
    wire logic buf_push = req_valid_in && req_ready_out;
    wire logic buf_pop = buf_cnt != 2'h0 && link_ready;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            buf_cnt <= 2'h0;
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            req_ready_out <= 1'b0;
        end else begin
            if (buf_push) begin
                buf_q[buf_wp] <= {req_cmd_in, req_ba_in, req_cke_in, req_addr_in, req_data_in};
                buf_wp <= !buf_wp;
            end
            if (buf_pop) buf_rp <= !buf_rp;
            buf_cnt <= buf_cnt + 2'(buf_push) - 2'(buf_pop);
            req_ready_out <= (buf_cnt + 2'(buf_push) - 2'(buf_pop)) != 2'h2;
        end
    end

    // Link clock divider: command changes on falling edge, sampled on rising
    logic [1:0] div;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div <= 2'h0;
            link.ck <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h1) link.ck <= 1'b1;
            if (div == 2'h3) link.ck <= 1'b0;
        end
    end
    wire logic launch = div == 2'h3;
    assign link_ready = launch;

    // Refresh pacing halves when hot
    logic [15:0] refi;
    wire logic [15:0] refi_limit = hot_in ? 16'(REFI_CYC / 2) : 16'(REFI_CYC);
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            refi <= 16'h0000;
            refresh_due_out <= 1'b0;
        end else begin
            refi <= refi + 16'h0001;
            // Count runs 0 to limit-1, so requests are exactly limit cycles apart
            if (refi + 16'h0001 >= refi_limit) begin
                refi <= 16'h0000;
                refresh_due_out <= 1'b1;
            end else if (launch && !(buf_cnt != 2'h0)) begin
                refresh_due_out <= 1'b0;
            end
        end
    end

    wire logic [31:0] head = buf_q[buf_rp];
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link.cke <= 1'b0;
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_DES;
            link.ba <= 3'h0;
            link.addr <= 16'h0000;
            link.ctl_dq <= 8'h00;
            link.ctl_dq_oe <= 1'b0;
            link.ctl_dqs <= 1'b0;
            link.ctl_dqs_oe <= 1'b0;
        end else if (launch) begin
            if (buf_cnt != 2'h0) begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= head[31:28];
                link.ba <= head[27:25];
                link.cke <= head[24];
                link.addr <= head[23:8];
                link.ctl_dq <= head[7:0];
                link.ctl_dq_oe <= head[31:28] == CMD_WR;
                link.ctl_dqs_oe <= head[31:28] == CMD_WR;
                link.ctl_dqs <= !link.ctl_dqs;
            end else if (refresh_due_out) begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
                link.cke <= 1'b1;
                link.ctl_dq_oe <= 1'b0;
                link.ctl_dqs_oe <= 1'b0;
            end else begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
                link.ctl_dq_oe <= 1'b0;
                link.ctl_dqs_oe <= 1'b0;
            end
        end
    end
endmodule : ddr3_ctrl_end

// >>> ddr3_link_assertions.sv
// Checker for the link pins between the controller end and the memory end.
// Assumes both ends share one core clock and the controller divides the link clock by four.
`timescale 1ns/1ns
module ddr3_link_checker (
    // Clock and reset
    input logic core_clk_in,
    input logic rstn_in,
    // Link pins
    input logic ck,
    input logic cke,
    input logic cs_n,
    input logic ras_n,
    input logic cas_n,
    input logic we_n,
    input logic [2:0] ba,
    input logic [15:0] addr,
    input logic ctl_dq_oe,
    input logic mem_dq_oe,
    input logic mem_dqs,
    input logic mem_dqs_oe
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    logic [25:0] pins;
    assign pins = {cke, cs_n, ras_n, cas_n, we_n, ba, addr};

    AST_CK_DIV: assert property ($rose(ck) |=> ck ##1 !ck ##1 !ck ##1 ck)
        else $error("link clock is not a divide-by-four square wave");
    // Pins may only move while ck is low, so the rising crossing never sees a change
    AST_PINS_MOVE_CK_LOW: assert property ($changed(pins) |-> !ck)
        else $error("command pins changed while link clock high");
    AST_PINS_HOLD_RISE: assert property ($rose(ck) |-> $stable(pins) ##1 $stable(pins))
        else $error("command pins not held across rising link clock");
    AST_DQ_ONE_DRIVER: assert property (!(ctl_dq_oe && mem_dq_oe))
        else $error("both ends drive the data bus");
    AST_DQS_WITH_DQ: assert property (mem_dq_oe |-> mem_dqs_oe)
        else $error("read data driven without strobe");
    AST_READ_HALF_CK: assert property (
        mem_dqs_oe && $past(mem_dqs_oe) && $changed(mem_dqs) |=> $stable(mem_dqs))
        else $error("read strobe toggles faster than half a link clock");
    AST_READ_MIN_BEATS: assert property ($rose(mem_dqs_oe) |-> mem_dqs_oe [*8])
        else $error("read burst shorter than four beats");
    AST_READ_ENDS: assert property ($rose(mem_dqs_oe) |-> ##[8:40] !mem_dqs_oe)
        else $error("read burst does not end");
endmodule : ddr3_link_checker

// >>> testbench.sv
// Testbench joining controller end and memory end through the link interface.
// Assumes user requests go through the controller; device state is seen on status ports.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench
    import ddr3_link_pkg::*;
;
    localparam int REFI = 20;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    logic [3:0] req_cmd = CMD_NOP;
    logic [2:0] req_ba = 3'h0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_data = 8'h00;
    logic req_cke = 1'b1;
    logic hot = 1'b0;
    logic req_ready, refresh_due, powerdown, self_refresh;
    logic [7:0] open_banks;
    logic [1:0] mode_bl;
    logic [15:0] refresh_count, rc0;
    int err_total = 0;
    int check_count = 0;
    int n_full, n_chop, gap;
    logic [1:0] bls [3] = '{BL_FIXED4, BL_FIXED8, BL_OTF};

    always #20 core_clk = ~core_clk;

    ddr3_link_if link();
    ddr3_ctrl_end #(.REFI_CYC(REFI)) ddr3_ctrl_end_i (.core_clk_in(core_clk), .rstn_in(rstn),
        .req_valid_in(req_valid), .req_cmd_in(req_cmd), .req_ba_in(req_ba),
        .req_addr_in(req_addr), .req_data_in(req_data), .req_cke_in(req_cke),
        .hot_in(hot), .req_ready_out(req_ready), .refresh_due_out(refresh_due), .link(link));
    ddr3_memory_end ddr3_memory_end_i (.core_clk_in(core_clk), .rstn_in(rstn), .link(link),
        .powerdown_out(powerdown), .self_refresh_out(self_refresh),
        .open_banks_out(open_banks), .mode_bl_out(mode_bl), .refresh_count_out(refresh_count));
    ddr3_link_checker ddr3_link_checker_i (.core_clk_in(core_clk), .rstn_in(rstn),
        .ck(link.ck), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
        .ctl_dq_oe(link.ctl_dq_oe), .mem_dq_oe(link.mem_dq_oe), .mem_dqs(link.mem_dqs),
        .mem_dqs_oe(link.mem_dqs_oe));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    function automatic logic [15:0] pick(input int sel);
        case (sel)
            0: return {8'h00, open_banks};
            1: return {14'h0000, mode_bl};
            2: return {15'h0000, powerdown};
            3: return {15'h0000, self_refresh};
            default: return {15'h0000, link.mem_dqs_oe};
        endcase
    endfunction : pick

    // Request is held from a falling edge until a rising edge samples ready high
    task automatic send(input logic [3:0] cmd, input logic [2:0] ba, input logic [15:0] addr,
        input logic cke);
        int n;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_cmd = cmd;
        req_ba = ba;
        req_addr = addr;
        req_cke = cke;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        @(negedge core_clk);
        req_valid = 1'b0;
        if (n >= 200) begin
            err_total++;
            print_verdict();
        end
    endtask : send

    // Device reacts after the link clock and synchroniser lag, so poll under a bound
    task automatic expect_eq(input int sel, input logic [15:0] exp, input string nm);
        logic [15:0] got;
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            got = pick(sel);
            n++;
        end while (got !== exp && n < 300);
        `CHK(nm, exp, got)
        if (n >= 300) print_verdict();
    endtask : expect_eq

    task automatic read_len(input logic [15:0] addr, output int len);
        send(CMD_RD, 3'h2, addr, 1'b1);
        expect_eq(4, 16'h0001, "read strobe on");
        len = 0;
        while (link.mem_dqs_oe === 1'b1 && len < 100) begin
            @(negedge core_clk);
            len++;
        end
    endtask : read_len

    task automatic refresh_gap(output int n);
        logic prev;
        n = 0;
        prev = refresh_due;
        do begin
            @(negedge core_clk);
            n++;
            if (refresh_due === 1'b1 && prev !== 1'b1 && n > 1) break;
            prev = refresh_due;
        end while (n < 300);
        if (n >= 300) begin
            err_total++;
            print_verdict();
        end
    endtask : refresh_gap

    initial begin
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        `CHK("reset cke", 1'b0, link.cke)
        `CHK("reset cs_n", 1'b1, link.cs_n)
        `CHK("reset banks", 8'h00, open_banks)
        `CHK("reset mode", 2'h0, mode_bl)
        `CHK("reset pd", 1'b0, powerdown)
        `CHK("reset sr", 1'b0, self_refresh)
        // Device ignores a command whose previous link clock saw CKE low
        send(CMD_NOP, 3'h0, 16'h0000, 1'b1);
        foreach (bls[i]) begin
            send(CMD_MRS, 3'h0, {14'h0000, bls[i]}, 1'b1);
            expect_eq(1, {14'h0000, bls[i]}, "burst length");
        end
        // Second mode register carries a BL-looking pattern that must not land in MR0
        send(CMD_MRS, 3'h1, {11'h000, AL_CL1, 1'b0, 2'h2}, 1'b1);
        for (int b = 0; b < BANK_COUNT; b++) begin
            send(CMD_ACT, 3'(b), 16'(b * 16'h1111), 1'b1);
            expect_eq(0, 16'((1 << (b + 1)) - 1), "open banks");
        end
        `CHK("mode kept", BL_OTF, mode_bl)
        send(4'hA, 3'h0, 16'h0000, 1'b1);
        send(CMD_PRE, 3'h1, 16'h0000, 1'b1);
        expect_eq(0, 16'h00FD, "single precharge");
        send(CMD_PRE, 3'h0, 16'h0400, 1'b1);
        expect_eq(0, 16'h0000, "precharge all");
        send(CMD_ACT, 3'h2, 16'h0123, 1'b1);
        expect_eq(0, 16'h0004, "bank two open");
        read_len(16'h1005, n_full);
        read_len(16'h0005, n_chop);
        `CHK("chop shortens by four beats", 8, n_full - n_chop)
        read_len(16'h1405, n_full);
        expect_eq(0, 16'h0000, "auto precharge");
        rc0 = refresh_count;
        refresh_gap(gap);
        refresh_gap(gap);
        `CHK("refresh spacing", REFI, gap)
        @(negedge core_clk);
        hot = 1'b1;
        refresh_gap(gap);
        refresh_gap(gap);
        `CHK("hot refresh spacing", REFI / 2, gap)
        @(negedge core_clk);
        hot = 1'b0;
        `CHK("auto refresh counted", 1'b1, refresh_count != rc0)
        send(CMD_NOP, 3'h0, 16'h0000, 1'b0);
        expect_eq(2, 16'h0001, "power-down entry");
        send(CMD_NOP, 3'h0, 16'h0000, 1'b1);
        expect_eq(2, 16'h0000, "power-down exit");
        send(CMD_REF, 3'h0, 16'h0000, 1'b0);
        expect_eq(3, 16'h0001, "self refresh entry");
        print_verdict();
    end
endmodule : testbench
